// >>> common/i2c_master_consts.vh
// What this block does
// RL1 - Write-complete sets after address or byte
// RL2 - Writing one clears status flags
// RL3 - Clock-hold flag and its clearing accesses
// RL4 - Read-only bit holds last slave ack
// RL5 - Arbitration lost on high bit, NACK, start
// RL6 - Software checks arbitration, then writes address
// RL7 - Illegal start or stop sets bus error
// RL8 - Bus error needs enable and fast clock
// RL9 - Bus state unknown after reset, disable
// RL10 - Writing one forces bus state idle
// RL11 - Baud field sets SCL high/low time
// RL12 - Address write while unknown: error, done
// RL13 - Address write: wait idle, start, send
// RL14 - Owned bus: repeated start, ack first
// RL15 - Address bit 0 selects read direction
// RL16 - Address write clears all master flags
// RL17 - Address read has no side effect
// RL18 - Data register is shift register, guarded
// RL19 - Data write sends byte, samples ack
// RL20 - Lost arbitration: clock remaining bits as ones
// RL21 - Data read: ack, one byte, read-complete
// RL22 - Data read with action clears interrupt flags
// RL23 - Ack-action is plain control bit
// RL24 - Read-complete only on clean, acked read
`ifndef I2C_MASTER_CONSTS_VH
`define I2C_MASTER_CONSTS_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OFS_MASTER_CONTROL_A 4'h3
`define OFS_MASTER_CONTROL_B 4'h4
`define OFS_MASTER_STATUS 4'h5
`define OFS_MASTER_BAUD_RATE 4'h6
`define OFS_MASTER_ADDRESS 4'h7
`define OFS_MASTER_DATA_SHIFT 4'h8
`define OFS_SLAVE_CONTROL_A 4'h9

// ------------------------------------------------------------
// Field positions and values
// ------------------------------------------------------------
`define BIT_READ_FLAG 7
`define BIT_WRITE_FLAG 6
`define BIT_STRETCH_FLAG 5
`define BIT_RX_ACK 4
`define BIT_ARB_LOST 3
`define BIT_BUS_ERROR 2
`define BIT_ENABLE 0
`define BIT_ACK_ACTION 2
`define BUS_UNKNOWN 2'h0
`define BUS_IDLE 2'h1
`define BUS_OWNER 2'h2
`define BUS_BUSY 2'h3
`define CMD_NONE 2'h0
`define CMD_REPSTART 2'h1
`define CMD_RECV 2'h2
`define CMD_STOP 2'h3
`define RESET_BYTE 8'h00

`endif

// >>> logic/i2c_master_status_data_path.v
`timescale 1ns/10ps
`default_nettype none
`include "i2c_master_consts.vh"

module i2c_master_status_data_path (
  // Clock and reset
  input wire core_clk,
  input wire reset,
  // Register port
  input wire [3:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  // Bus pins
  input wire sclIn,
  output wire sclOut,
  output wire sclOe,
  input wire sdaIn,
  output wire sdaOut,
  output wire sdaOe
);

// ------------------------------------------------------------
// Pin synchronisers and bus condition detection
// ------------------------------------------------------------
reg [1:0] sclSync_r;
reg [1:0] sdaSync_r;
reg sclPrev_r;
reg sdaPrev_r;
always @(posedge core_clk) begin
  if (reset) begin
    sclSync_r <= 2'h3;
    sdaSync_r <= 2'h3;
    sclPrev_r <= 1'b1;
    sdaPrev_r <= 1'b1;
  end else begin
    sclSync_r <= {sclSync_r[0], sclIn};
    sdaSync_r <= {sdaSync_r[0], sdaIn};
    sclPrev_r <= sclSync_r[1];
    sdaPrev_r <= sdaSync_r[1];
  end
end
wire scl = sclSync_r[1];
wire sda = sdaSync_r[1];
wire startSeen = scl && sclPrev_r && sdaPrev_r && !sda;
wire stopSeen = scl && sclPrev_r && !sdaPrev_r && sda;

// ------------------------------------------------------------
// Registers
// ------------------------------------------------------------
reg [7:0] controlA_r;
reg ackAction_r;
reg [7:0] baud_r;
reg [7:0] address_r;
reg [7:0] shift_r;
reg [7:0] slaveCtrlA_r;
reg readFlag_r;
reg writeFlag_r;
reg stretch_r;
reg received_ack_bit_r;
reg arbitration_lost_flag_r;
reg bus_error_flag_r;
reg [1:0] bus_state_field_r;
reg enPrev_r;
wire enable = controlA_r[`BIT_ENABLE];

// Access decode
wire wrStatus = regWrite && regAddr == `OFS_MASTER_STATUS;
wire wrAddr = regWrite && regAddr == `OFS_MASTER_ADDRESS;
wire wrData = regWrite && regAddr == `OFS_MASTER_DATA_SHIFT;
wire rdData = regRead && regAddr == `OFS_MASTER_DATA_SHIFT;
wire wrCtrlB = regWrite && regAddr == `OFS_MASTER_CONTROL_B;
wire validCmd = wrCtrlB && regWrData[1:0] != `CMD_NONE;

// ------------------------------------------------------------
// Engine states
// ------------------------------------------------------------
localparam ST_IDLE = 8'h01;
localparam ST_WAIT = 8'h02;
localparam ST_START = 8'h04;
localparam ST_BITLO = 8'h08;
localparam ST_BITHI = 8'h10;
localparam ST_HOLD = 8'h20;
localparam ST_STOP = 8'h40;
localparam ST_ACKO = 8'h80;
reg [7:0] state_r;
reg [3:0] bitCnt_r;
reg [7:0] divCnt_r;
reg rxMode_r;
reg lastWasRead_r;
reg lostInOp_r;
reg errInOp_r;
reg nextRead_r;
reg nextStart_r;
reg nextStop_r;
reg phase_r;
reg sclDrv_r;
reg sdaDrv_r;
// RL11 baud timing
wire tick = divCnt_r == 8'h00;
// Start that this master drives itself, not a foreign one
wire ownStart = startSeen && sdaDrv_r && !sclDrv_r;

// Byte shifting
wire shifting = state_r == ST_BITLO || state_r == ST_BITHI || state_r == ST_START || state_r == ST_ACKO;
wire bitOut = rxMode_r ? 1'b1 : (bitCnt_r == 4'h8 ? 1'b1 : shift_r[7]);
// Receive ends after eight bits, the acknowledge waits for software
wire lastBit = rxMode_r ? bitCnt_r == 4'h7 : bitCnt_r == 4'h8;

// ------------------------------------------------------------
// Bus state tracker
// ------------------------------------------------------------
always @(posedge core_clk) begin
  if (reset) begin
    bus_state_field_r <= `BUS_UNKNOWN;
    enPrev_r <= 1'b0;
  end else begin
    enPrev_r <= enable;
    // RL9 unknown on disable
    if (!enable || !enPrev_r)
      bus_state_field_r <= `BUS_UNKNOWN;
    // RL10 force idle
    else if (wrStatus && regWrData[1:0] == `BUS_IDLE)
      bus_state_field_r <= `BUS_IDLE;
    else if (stopSeen)
      bus_state_field_r <= `BUS_IDLE;
    else if (startSeen)
      bus_state_field_r <= ownStart ? `BUS_OWNER : `BUS_BUSY;
    else if (state_r == ST_STOP && phase_r && !sclDrv_r && tick)
      bus_state_field_r <= `BUS_IDLE;
  end
end

// ------------------------------------------------------------
// Master engine and status flags
// ------------------------------------------------------------
always @(posedge core_clk) begin
  if (reset) begin
    state_r <= ST_IDLE;
    bitCnt_r <= 4'h0;
    divCnt_r <= 8'h00;
    rxMode_r <= 1'b0;
    lastWasRead_r <= 1'b0;
    lostInOp_r <= 1'b0;
    errInOp_r <= 1'b0;
    nextRead_r <= 1'b0;
    nextStart_r <= 1'b0;
    nextStop_r <= 1'b0;
    phase_r <= 1'b0;
    sclDrv_r <= 1'b0;
    sdaDrv_r <= 1'b0;
    shift_r <= `RESET_BYTE;
    readFlag_r <= 1'b0;
    writeFlag_r <= 1'b0;
    stretch_r <= 1'b0;
    received_ack_bit_r <= 1'b0;
    arbitration_lost_flag_r <= 1'b0;
    bus_error_flag_r <= 1'b0;
  end else begin
    divCnt_r <= tick ? baud_r : divCnt_r - 8'h01;
    // RL2 write-one clears
    if (wrStatus) begin
      if (regWrData[`BIT_READ_FLAG]) readFlag_r <= 1'b0;
      if (regWrData[`BIT_WRITE_FLAG]) writeFlag_r <= 1'b0;
      if (regWrData[`BIT_STRETCH_FLAG]) stretch_r <= 1'b0;
      if (regWrData[`BIT_ARB_LOST]) arbitration_lost_flag_r <= 1'b0;
      if (regWrData[`BIT_BUS_ERROR]) bus_error_flag_r <= 1'b0;
    end
    // RL3 access clears hold
    if (wrAddr || wrData || rdData || validCmd) begin
      stretch_r <= 1'b0;
      readFlag_r <= 1'b0;
      writeFlag_r <= 1'b0;
    end
    // RL16 address clears all
    if (wrAddr || validCmd) begin
      arbitration_lost_flag_r <= 1'b0;
      bus_error_flag_r <= 1'b0;
    end
    // RL7 protocol violation
    // RL8 only while enabled
    if (enable && bus_state_field_r != `BUS_UNKNOWN && (startSeen || stopSeen) && !ownStart &&
        (shifting && state_r != ST_START || state_r == ST_START && stopSeen)) begin
      bus_error_flag_r <= 1'b1;
      errInOp_r <= 1'b1;
    end
    case (state_r)
      ST_IDLE, ST_HOLD: begin
        if (wrAddr) begin
          lostInOp_r <= 1'b0;
          errInOp_r <= 1'b0;
          nextRead_r <= regWrData[0];
          // RL12 unknown bus
          if (bus_state_field_r == `BUS_UNKNOWN || !enable) begin
            writeFlag_r <= 1'b1;
            bus_error_flag_r <= 1'b1;
            state_r <= ST_IDLE;
          // RL14 repeated start
          end else if (bus_state_field_r == `BUS_OWNER) begin
            shift_r <= regWrData;
            nextStart_r <= 1'b1;
            state_r <= lastWasRead_r ? ST_ACKO : ST_START;
            phase_r <= 1'b0;
          // RL13 wait for idle
          end else begin
            shift_r <= regWrData;
            state_r <= ST_WAIT;
          end
        // RL18 data write only while holding
        end else if (wrData && state_r == ST_HOLD) begin
          // RL19 byte write
          shift_r <= regWrData;
          rxMode_r <= 1'b0;
          lastWasRead_r <= 1'b0;
          bitCnt_r <= 4'h0;
          phase_r <= 1'b0;
          state_r <= ST_BITLO;
        // RL21 read with ack first
        // RL22 read clears flags
        end else if (rdData && state_r == ST_HOLD && lastWasRead_r) begin
          nextStart_r <= 1'b0;
          nextStop_r <= 1'b0;
          state_r <= ST_ACKO;
          phase_r <= 1'b0;
        end else if (validCmd && state_r == ST_HOLD) begin
          nextStart_r <= regWrData[1:0] == `CMD_REPSTART;
          nextStop_r <= regWrData[1:0] == `CMD_STOP;
          state_r <= lastWasRead_r ? ST_ACKO : (regWrData[1:0] == `CMD_STOP ? ST_STOP : ST_HOLD);
          phase_r <= 1'b0;
        end
      end
      ST_WAIT: begin
        if (bus_state_field_r == `BUS_IDLE) begin
          state_r <= ST_START;
          phase_r <= 1'b0;
        end
      end
      ST_ACKO: begin
        // Send pending acknowledge action as one extra bit
        if (tick) begin
          phase_r <= !phase_r;
          if (!phase_r) begin
            sclDrv_r <= 1'b1;
            sdaDrv_r <= !ackAction_r;
          end else begin
            sclDrv_r <= 1'b0;
            // RL5 lost on NACK
            if (ackAction_r && !sda) begin
              arbitration_lost_flag_r <= 1'b1;
              lostInOp_r <= 1'b1;
              writeFlag_r <= 1'b1;
              state_r <= ST_IDLE;
            end else if (nextStart_r)
              state_r <= ST_START;
            else if (nextStop_r)
              state_r <= ST_STOP;
            else begin
              rxMode_r <= 1'b1;
              bitCnt_r <= 4'h0;
              state_r <= ST_BITLO;
            end
            phase_r <= 1'b0;
          end
        end
      end
      ST_START: begin
        // Release both lines, then pull data low with clock high
        if (tick) begin
          phase_r <= !phase_r;
          if (!phase_r) begin
            sclDrv_r <= 1'b0;
            sdaDrv_r <= 1'b0;
          end else if (scl && sda) begin
            sdaDrv_r <= 1'b1;
            rxMode_r <= 1'b0;
            bitCnt_r <= 4'h0;
            nextStart_r <= 1'b0;
            state_r <= ST_BITLO;
            phase_r <= 1'b0;
          // RL5 lost during start
          end else if (!sda) begin
            arbitration_lost_flag_r <= 1'b1;
            writeFlag_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
      end
      ST_BITLO: begin
        if (tick) begin
          sclDrv_r <= 1'b1;
          // RL20 ones after loss
          sdaDrv_r <= lostInOp_r ? 1'b0 : !bitOut;
          state_r <= ST_BITHI;
        end
      end
      ST_BITHI: begin
        if (tick && !sclDrv_r && scl) begin
          sclDrv_r <= 1'b1;
          bitCnt_r <= bitCnt_r + 4'h1;
          if (rxMode_r) shift_r <= {shift_r[6:0], sda};
          else if (bitCnt_r != 4'h8) shift_r <= {shift_r[6:0], 1'b1};
          if (lastBit) begin
            // RL4 latest ack
            if (!rxMode_r) received_ack_bit_r <= sda;
            // RL1 write complete
            if (!rxMode_r && !nextRead_r || !rxMode_r && lostInOp_r || rxMode_r && (lostInOp_r || errInOp_r))
              writeFlag_r <= 1'b1;
            // RL15 address read direction
            if (!rxMode_r && nextRead_r && !lostInOp_r && !sda) begin
              nextRead_r <= 1'b0;
              rxMode_r <= 1'b1;
              bitCnt_r <= 4'h0;
              state_r <= ST_BITLO;
            end else begin
              stretch_r <= !lostInOp_r;
              // RL24 clean read
              if (rxMode_r && !lostInOp_r && !errInOp_r)
                readFlag_r <= 1'b1;
              if (!rxMode_r && nextRead_r) begin
                writeFlag_r <= 1'b1;
                nextRead_r <= 1'b0;
              end
              lastWasRead_r <= rxMode_r;
              state_r <= lostInOp_r ? ST_IDLE : ST_HOLD;
            end
          end else begin
            // RL5 lost on high bit
            if (!rxMode_r && !lostInOp_r && bitOut && !sda) begin
              arbitration_lost_flag_r <= 1'b1;
              lostInOp_r <= 1'b1;
            end
            state_r <= ST_BITLO;
          end
        end else if (tick) begin
          sclDrv_r <= 1'b0;
        end
      end
      ST_STOP: begin
        // Clock low, data low, clock high, then data high
        if (tick) begin
          if (!phase_r) begin
            if (!sclDrv_r) begin
              sclDrv_r <= 1'b1;
            end else begin
              sdaDrv_r <= 1'b1;
              phase_r <= 1'b1;
            end
          end else if (sclDrv_r) begin
            sclDrv_r <= 1'b0;
          end else begin
            sdaDrv_r <= 1'b0;
            phase_r <= 1'b0;
            state_r <= ST_IDLE;
          end
        end
      end
      default: state_r <= ST_IDLE;
    endcase
    if (!enable) begin
      state_r <= ST_IDLE;
      sclDrv_r <= 1'b0;
      sdaDrv_r <= 1'b0;
      stretch_r <= 1'b0;
    end
  end
end
// ------------------------------------------------------------
// Control register writes
// ------------------------------------------------------------
always @(posedge core_clk) begin
  if (reset) begin
    controlA_r <= `RESET_BYTE;
    ackAction_r <= 1'b0;
    baud_r <= `RESET_BYTE;
    address_r <= `RESET_BYTE;
    slaveCtrlA_r <= `RESET_BYTE;
  end else if (regWrite) begin
    case (regAddr)
      `OFS_MASTER_CONTROL_A: controlA_r <= regWrData;
      // RL23 plain control bit
      `OFS_MASTER_CONTROL_B: ackAction_r <= regWrData[`BIT_ACK_ACTION];
      `OFS_MASTER_BAUD_RATE: baud_r <= regWrData;
      `OFS_MASTER_ADDRESS: address_r <= regWrData;
      `OFS_SLAVE_CONTROL_A: slaveCtrlA_r <= regWrData;
      default: ;
    endcase
  end
end

// ------------------------------------------------------------
// Read data, one cycle after the strobe
// ------------------------------------------------------------
always @(posedge core_clk) begin
  if (reset) begin
    regRdData <= `RESET_BYTE;
  end else if (regRead) begin
    case (regAddr)
      `OFS_MASTER_CONTROL_A: regRdData <= controlA_r;
      `OFS_MASTER_CONTROL_B: regRdData <= {5'h00, ackAction_r, 2'h0};
      `OFS_MASTER_STATUS:
        regRdData <= {readFlag_r, writeFlag_r, stretch_r, received_ack_bit_r, arbitration_lost_flag_r, bus_error_flag_r, bus_state_field_r};
      `OFS_MASTER_BAUD_RATE: regRdData <= baud_r;
      // RL17 side-effect free
      `OFS_MASTER_ADDRESS: regRdData <= address_r;
      `OFS_MASTER_DATA_SHIFT: regRdData <= shift_r;
      `OFS_SLAVE_CONTROL_A: regRdData <= slaveCtrlA_r;
      default: regRdData <= `RESET_BYTE;
    endcase
  end else begin
    regRdData <= `RESET_BYTE;
  end
end

// Open-drain pins: drive low only
assign sclOut = 1'b0;
assign sdaOut = 1'b0;
// RL3 hold clock low
assign sclOe = sclDrv_r | stretch_r;
assign sdaOe = sdaDrv_r;

endmodule // i2c_master_status_data_path
`default_nettype wire

// >>> testbench/i2c_master_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2c_master_consts.vh"

module i2c_master_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regRdData,
  // Bus pins
  input wire logic sclIn,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe
);
  logic enR;
  logic knownR;
  logic [7:0] addrR;

  // ----------------------------------------
  // Shadow of enable, forced idle, address
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      enR <= 1'b0;
      knownR <= 1'b0;
      addrR <= 8'h00;
    end else if (regWrite) begin
      if (regAddr == `OFS_MASTER_CONTROL_A) begin
        enR <= regWrData[`BIT_ENABLE];
        knownR <= 1'b0;
      end
      if (regAddr == `OFS_MASTER_STATUS && regWrData[1:0] == `BUS_IDLE && enR) begin
        knownR <= 1'b1;
      end
      if (regAddr == `OFS_MASTER_ADDRESS) begin
        addrR <= regWrData;
      end
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  read_quiet_a: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("Read data not zero outside read cycle");
  pins_low_a: assert property (!sclOut && !sdaOut)
    else $error("Bus outputs do not pull low");
  no_drive_a: assert property ((!knownR)[*3] |-> !sclOe && !sdaOe)
    else $error("Bus driven while state unknown");
  idle_force_a: assert property (regWrite && regAddr == `OFS_MASTER_STATUS && regWrData[1:0] == 2'h1 && enR
    ##2 regRead && regAddr == `OFS_MASTER_STATUS |=> regRdData[1:0] == 2'h1) else $error("Idle not forced");
  dis_unknown_a: assert property (!enR && regRead && regAddr == `OFS_MASTER_STATUS |=> regRdData[1:0] == 2'h0)
    else $error("Bus state known while disabled");
  one_clear_a: assert property (regWrite && regAddr == `OFS_MASTER_STATUS && regWrData == 8'hec
    ##2 regRead && regAddr == `OFS_MASTER_STATUS |=> (regRdData & 8'hec) == 8'h00) else $error("Flags not cleared");
  addr_clear_a: assert property (regWrite && regAddr == `OFS_MASTER_ADDRESS && knownR
    ##2 regRead && regAddr == `OFS_MASTER_STATUS |=> (regRdData & 8'hec) == 8'h00) else $error("Address kept flags");
  unknown_addr_a: assert property (regWrite && regAddr == `OFS_MASTER_ADDRESS && enR && !knownR
    ##2 regRead && regAddr == `OFS_MASTER_STATUS |=> regRdData[6] && regRdData[2]) else $error("No error on unknown");
  addr_read_a: assert property (regRead && regAddr == `OFS_MASTER_ADDRESS |=> regRdData == $past(addrR))
    else $error("Address read back wrong");
endmodule // i2c_master_sva

bind i2c_master_status_data_path i2c_master_sva i2c_master_sva_inst (.core_clk(core_clk), .reset(reset),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));
`default_nettype wire

// >>> testbench/i2c_slave_model.sv
`timescale 1ns/10ps
`default_nettype none

module i2c_slave_model (
  // Bus wires
  input wire logic scl,
  input wire logic sda,
  output var logic sdaLow,
  // Test controls
  input wire logic ackOk,
  input wire logic [7:0] rdByte,
  output var logic [7:0] lastByte
);
  int bitCnt = 0;
  logic isAddr = 1'b0;
  logic rdMode = 1'b0;
  logic [7:0] shiftIn = 8'h00;

  // Start opens an address byte
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bitCnt = 0;
      isAddr = 1'b1;
      rdMode = 1'b0;
    end
  end

  // Stop releases the line
  always @(posedge sda) begin
    if (scl === 1'b1) begin
      isAddr = 1'b0;
      rdMode = 1'b0;
      sdaLow = 1'b0;
    end
  end

  // Sample bits and the master ack
  always @(posedge scl) begin
    if (bitCnt < 8) begin
      shiftIn = {shiftIn[6:0], sda};
    end else if (rdMode && !isAddr && sda) begin
      rdMode = 1'b0;
    end
    bitCnt = bitCnt + 1;
    if (bitCnt == 8 && !rdMode) begin
      lastByte = shiftIn;
    end
  end

  // Drive ack and read bits while clock low
  initial begin
    sdaLow = 1'b0;
    lastByte = 8'h00;
  end
  always @(negedge scl) begin
    if (bitCnt == 8) begin
      sdaLow = (isAddr || !rdMode) ? ackOk : 1'b0;
    end else if (bitCnt == 9) begin
      bitCnt = 0;
      if (isAddr) begin
        rdMode = shiftIn[0];
      end
      isAddr = 1'b0;
      sdaLow = rdMode & ~rdByte[7];
    end else if (rdMode && !isAddr && bitCnt > 0) begin
      sdaLow = ~rdByte[7 - bitCnt];
    end
  end
endmodule // i2c_slave_model
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "i2c_master_consts.vh"

module tb_top;
  logic core_clk, reset, regWrite, regRead, sclOe, sdaOe, sdaLow, ackOk;
  logic [3:0] regAddr;
  logic [7:0] regWrData, regRdData, rdVal, lastByte;
  wire scl, sda;
  int badCount = 0;
  int checked = 0;

  // Open-drain wires with pull-ups
  assign scl = !(sclOe === 1'b1);
  assign sda = !(sdaOe === 1'b1 || sdaLow === 1'b1);

  i2c_master_status_data_path i2c_master_status_data_path_inst (.core_clk(core_clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .sclIn(scl), .sclOut(), .sclOe(sclOe), .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe));
  i2c_slave_model i2c_slave_model_inst (.scl(scl), .sda(sda), .sdaLow(sdaLow), .ackOk(ackOk),
    .rdByte(8'h96), .lastByte(lastByte));

  // ----------------------------------------
  // Clock and access tasks
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 rdVal = regRdData;
    @(posedge core_clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask, input string what);
    checked++;
    if ((got & mask) !== (exp & mask)) begin
      badCount++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rdChk(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] mask, input string what);
    rd(a);
    chk(rdVal, exp, mask, what);
  endtask
  task automatic waitStat(input logic [7:0] mask);
    int n;
    n = 0;
    rd(`OFS_MASTER_STATUS);
    while ((rdVal & mask) !== mask && n < 2000) begin
      rd(`OFS_MASTER_STATUS);
      n++;
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 4'h0;
    regWrData = 8'h00;
    ackOk = 1'b1;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    for (int i = 5; i < 10; i++) rdChk(4'(i), 8'h00, 8'hff, "reset value");
    rdChk(4'hf, 8'h00, 8'hff, "unmapped");
    wr(`OFS_MASTER_BAUD_RATE, 8'h07);
    rdChk(`OFS_MASTER_BAUD_RATE, 8'h07, 8'hff, "baud");
    wr(`OFS_SLAVE_CONTROL_A, 8'ha5);
    rdChk(`OFS_SLAVE_CONTROL_A, 8'ha5, 8'hff, "slave control");
    wr(`OFS_MASTER_CONTROL_B, 8'h04);
    rdChk(`OFS_MASTER_CONTROL_B, 8'h04, 8'h07, "ack action");
    wr(`OFS_MASTER_CONTROL_B, 8'h00);
    $display("registers test done");
    wr(`OFS_MASTER_CONTROL_A, 8'h01);
    rdChk(`OFS_MASTER_STATUS, 8'h00, 8'hff, "re-enabled");
    wr(`OFS_MASTER_ADDRESS, 8'ha0);
    rdChk(`OFS_MASTER_STATUS, 8'h44, 8'hff, "unknown address");
    chk(lastByte, 8'h00, 8'hff, "no traffic");
    wr(`OFS_MASTER_STATUS, 8'hec);
    rdChk(`OFS_MASTER_STATUS, 8'h00, 8'hff, "write one clear");
    wr(`OFS_MASTER_STATUS, 8'h01);
    rdChk(`OFS_MASTER_STATUS, 8'h01, 8'hff, "forced idle");
    $display("status test done");
    wr(`OFS_MASTER_ADDRESS, 8'ha0);
    rdChk(`OFS_MASTER_STATUS, 8'h00, 8'hec, "address clears");
    waitStat(8'h40);
    chk(rdVal, 8'h62, 8'hff, "address done");
    chk(lastByte, 8'ha0, 8'hff, "address byte");
    ackOk <= 1'b0;
    wr(`OFS_MASTER_DATA_SHIFT, 8'h5a);
    wr(`OFS_MASTER_DATA_SHIFT, 8'hff);
    waitStat(8'h40);
    chk(rdVal, 8'h72, 8'hff, "nack write");
    chk(lastByte, 8'h5a, 8'hff, "guarded byte");
    ackOk <= 1'b1;
    wr(`OFS_MASTER_DATA_SHIFT, 8'h3c);
    waitStat(8'h40);
    chk(rdVal, 8'h62, 8'hff, "ack write");
    chk(lastByte, 8'h3c, 8'hff, "data byte");
    $display("write test done");
    wr(`OFS_MASTER_ADDRESS, 8'ha1);
    waitStat(8'h80);
    chk(rdVal, 8'ha2, 8'hff, "read done");
    rdChk(`OFS_MASTER_DATA_SHIFT, 8'h96, 8'hff, "read byte");
    rdChk(`OFS_MASTER_STATUS, 8'h00, 8'he0, "read clears");
    waitStat(8'h80);
    wr(`OFS_MASTER_CONTROL_B, 8'h07);
    waitStat(8'h01);
    chk(rdVal, 8'h01, 8'hff, "stop idle");
    wr(`OFS_MASTER_CONTROL_A, 8'h00);
    rdChk(`OFS_MASTER_STATUS, 8'h00, 8'h03, "disabled");
    $display("read test done");
    conclude();
  end

  // Watchdog against a hung handshake
  initial begin
    #200000;
    badCount++;
    $display("watchdog expired");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
